// File: fpumts_pkg.sv
/*
  Shared constants and carrier types for the accumulator control block:
  coprocessor instruction encodings, latencies, status layout and the
  register map. Assumes a single 200 MHz system clock.
*/
package fpumts_pkg;

  // Function field
  localparam logic [2:0] FN_LOAD = 3'h0;
  localparam logic [2:0] FN_ADD = 3'h1;
  localparam logic [2:0] FN_SUB = 3'h2;
  localparam logic [2:0] FN_RSUB = 3'h3;
  localparam logic [2:0] FN_MISC = 3'h4;
  localparam logic [2:0] FN_MUL = 3'h5;
  localparam logic [2:0] FN_DIV = 3'h6;
  localparam logic [2:0] FN_RDIV = 3'h7;

  // Operand field: integer, then f/g input with f/g rounding
  localparam logic [2:0] OP_INT = 3'h0;
  localparam logic [2:0] OP_F = 3'h4;
  localparam logic [2:0] OP_FG = 3'h5;
  localparam logic [2:0] OP_GF = 3'h6;
  localparam logic [2:0] OP_G = 3'h7;

  // Result field
  localparam logic [2:0] RS_SIGN = 3'h0;
  localparam logic [2:0] RS_EXP = 3'h1;
  localparam logic [2:0] RS_INTH = 3'h2;
  localparam logic [2:0] RS_INTL = 3'h3;
  localparam logic [2:0] RS_DPH = 3'h4;
  localparam logic [2:0] RS_DPL = 3'h5;
  localparam logic [2:0] RS_SP = 3'h6;

  // Miscellaneous codes
  localparam logic [7:0] MC_FIX = 8'h50;
  localparam logic [7:0] MC_FLOAT_SP = 8'h48;
  localparam logic [7:0] MC_FLOAT_DP = 8'h58;
  localparam logic [7:0] MC_SCALE = 8'h68;
  localparam logic [7:0] MC_LOAD_EXPONENT = 8'h78;
  localparam logic [7:0] MC_WRITE_ACC_SIGN = 8'h08;
  localparam logic [7:0] MC_READ_CYCLE_CLOCK = 8'h18;
  localparam logic [7:0] MC_SET_TIMER_TARGET = 8'h30;
  localparam logic [7:0] MC_SET_CYCLE_CLOCK = 8'h38;
  localparam logic [7:0] MC_NOP = 8'h28;

  // Result latencies in cycles, issue cycle included
  localparam logic [5:0] LAT_ADD_FLT = 6'h04;
  localparam logic [5:0] LAT_ADD_FIX = 6'h01;
  localparam logic [5:0] LAT_MUL_F = 6'h08;
  localparam logic [5:0] LAT_MUL_G = 6'h12;
  localparam logic [5:0] LAT_MUL_FIX = 6'h06;
  localparam logic [5:0] LAT_DIV_F = 6'h1D;
  localparam logic [5:0] LAT_DIV_G = 6'h3A;
  localparam logic [5:0] LAT_DIV_FIX = 6'h22;
  localparam logic [5:0] LAT_FLOAT = 6'h03;
  localparam logic [5:0] LAT_OTHER = 6'h01;

  // Interval timer window, 2^19 - 1 cycles at most
  localparam logic [63:0] TIMER_WINDOW_MAX = 64'h0000_0000_0007_FFFF;

  // Exponent limits of the two external formats (unbiased)
  localparam logic signed [15:0] F_EXP_MAX = 16'sh007F;
  localparam logic signed [15:0] G_EXP_MAX = 16'sh03FF;

  // Status word bit positions
  localparam int ST_NEG = 0;
  localparam int ST_NZ = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_DRANGE = 3;
  localparam int ST_SRANGE = 4;
  localparam int ST_RESERVED_OPERAND_FLAG = 5;
  localparam int ST_ZDIV = 6;
  localparam int ST_TIMER = 7;

  // Register map, byte addresses
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_TOD_LO = 5'h04;
  localparam logic [4:0] REG_TOD_HI = 5'h08;
  localparam logic [4:0] REG_ACC_HI = 5'h0C;
  localparam logic [4:0] REG_ACC_LO = 5'h10;
  localparam logic [4:0] REG_ACC_EXP = 5'h14;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // One coprocessor instruction as issued by the pipeline
  typedef struct packed {
    logic valid;
    logic kernel;
    logic [2:0] func;
    logic [2:0] op;
    logic [2:0] fmt;
    logic [7:0] misc;
    logic [31:0] ra;
    logic [31:0] rb;
  } fpumts_issue_t;

  // Answer returned to the pipeline
  typedef struct packed {
    logic valid;
    logic trap;
    logic [31:0] data;
  } fpumts_result_t;

endpackage

// File: fpumts_cycle_clock.sv
/*
  Time-of-day counter with interval timer compare.
  Assumes the load strobes are single-cycle pulses from the control block
  in the same clock domain.
*/
`timescale 1ns/100ps
module fpumts_cycle_clock (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_tod_i,
  input wire logic load_target_i,
  input wire logic [63:0] value_i,
  output logic [63:0] tod_o,
  output logic pending_o
);
  import fpumts_pkg::*;

  logic [63:0] tod_r; // Cycle count
  logic [63:0] target_r; // Interrupt time
  logic armed_r; // Target is live
  logic pending_r; // Interrupt pending
  logic [63:0] ahead; // Distance from now to a new target
  logic in_window; // New target lies in the valid window
  logic hit; // Count reaches the live target

  assign ahead = value_i - tod_r;
  assign in_window = (ahead != 64'h0) && (ahead <= TIMER_WINDOW_MAX);
  assign hit = armed_r && (tod_r == target_r);

  // Counter runs every cycle; a load replaces it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tod_r <= 64'h0;
    end else if (load_tod_i) begin
      tod_r <= value_i;
    end else begin
      tod_r <= tod_r + 64'h1;
    end
  end

  // Target capture; a time-of-day load throws the target away
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      target_r <= 64'h0;
      armed_r <= 1'b0;
    end else if (load_tod_i) begin
      armed_r <= 1'b0;
    end else if (load_target_i) begin
      target_r <= value_i;
      armed_r <= in_window;
    end else if (hit) begin
      armed_r <= 1'b0;
    end
  end

  // Pending flag: a hit or a clock load sets it, a target load clears it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending_r <= 1'b0;
    end else if (load_tod_i || hit) begin
      pending_r <= 1'b1;
    end else if (load_target_i) begin
      pending_r <= 1'b0;
    end
  end

  assign tod_o = tod_r;
  assign pending_o = pending_r;
endmodule // fpumts_cycle_clock

// File: fpumts_core.sv
/*
  Accumulator control of the arithmetic coprocessor: miscellaneous
  functions, exception detection, status word, latency sequencing and an
  Avalon-MM register slave. Assumes the pipeline holds an instruction on
  issue_i until issue_ready_o is high, and that inputs are synchronous.
*/
// The address map and register access over Avalon-MM were chosen for this implementation.
// Behaviour
// - Code 50 fixes fraction, negating if negative
// - Codes 48/58 float operand pair, round f/g
// - Code 68 adds first operand to exponent
// - Code 78 loads exponent from first operand
// - Code 08 loads sign from operand bit 0
// - Code 18 copies time of day to fraction
// - Code 30 sets timer target, kernel only
// - Code 38 loads clock, drops target, interrupts
// - Code 28 changes nothing
// - Time of day is 64 bits, counts cycles
// - Near target fires interrupt on reaching it
// - Interrupt masked in kernel; target write clears
// - Float divide by zero traps, no divide
// - Reserved operand traps, operation skipped
// - Range error only on unrepresentable requested result
// - Status shows sign, nz, abort, flags, timer
// - Every untrapped instruction clears the abort flag
// - Status write loads two flags (reserved operand, zero divide), clears abort
// - Timer status bit follows timer continuously
// - Fixed-point operations raise no reserved operand or zero divide exceptions
// - Latencies follow the timing table
// - Wait, return result, start next together
`timescale 1ns/100ps
module fpumts_core (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire fpumts_pkg::fpumts_issue_t issue_i,
  output logic issue_ready_o,
  output fpumts_pkg::fpumts_result_t result_o,
  output logic timer_irq_o,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import fpumts_pkg::*;

  // Convert a fixed-point pair to sign, exponent and normalised fraction
  function automatic logic [80:0] to_float(input logic [63:0] v, input logic dbl);
    logic [63:0] mag;
    logic [63:0] norm;
    logic [64:0] sum;
    logic [63:0] half;
    logic [63:0] keep;
    logic signed [15:0] e;
    int p;
    mag = v[63] ? (~v + 64'h1) : v;
    p = 0;
    for (int i = 0; i < 64; i++) begin
      if (mag[i]) p = i;
    end
    norm = mag << (6'(62 - p));
    half = dbl ? 64'h0000_0000_0000_0200 : 64'h0000_0040_0000_0000;
    keep = dbl ? 64'hFFFF_FFFF_FFFF_FC00 : 64'hFFFF_FF80_0000_0000;
    sum = {1'b0, norm} + {1'b0, half}; // Round half up
    e = 16'(p - 31);
    if (sum[63]) begin
      sum = sum >> 1; // Carry out of the hidden bit
      e = e + 16'sh0001;
    end
    if (mag == 64'h0) to_float = 81'h0;
    else to_float = {v[63], e, sum[63:0] & keep};
  endfunction

  // Accumulator and status state
  logic acc_sign_r; // Accumulator sign
  logic signed [15:0] acc_exp_r; // Unbiased exponent
  logic [63:0] acc_frac_r; // Fraction, point right of bit 63
  logic abort_r, reserved_operand_flag_r, zdiv_r; // Exception flags; reserved operand and zero divide are sticky
  logic [5:0] busy_cnt_r; // Cycles left of current operation
  fpumts_result_t result_r; // Answer to the pipeline
  logic bus_ack_r; // Bus answer cycle
  logic [31:0] readdata_r; // Bus read data

  // Timer interface
  logic [63:0] tod; // Current time of day
  logic timer_pending; // Interval timer state
  logic load_tod, load_target; // Kernel-mode timer loads

  // Issue decode
  logic take; // Instruction accepted this cycle
  logic is_misc, is_fix, g_in, g_round; // Instruction class
  logic [63:0] operand; // Operand pair
  logic f_rsv, g_rsv, rsv_hit; // Reserved operand present
  logic op_zero, acc_zero, zdiv_hit; // Divide by zero present
  logic srange, drange, range_hit; // Range flags and range trap
  logic trap; // Any trap of this instruction
  logic [5:0] latency; // Latency of the new operation
  logic [31:0] status_word; // Assembled status
  logic [31:0] selected; // Selected accumulator portion
  logic [80:0] float_val; // Conversion result
  logic signed [15:0] fix_shift; // Right shift for fix
  logic [63:0] fix_mag; // Shifted fraction
  logic [63:0] fix_sum; // Fixed-point add/subtract result

  // Bus decode
  logic bus_req; // Read or write pending
  logic status_wr; // Status write takes effect

  fpumts_cycle_clock u_clock (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_tod_i(load_tod),
    .load_target_i(load_target),
    .value_i(operand),
    .tod_o(tod),
    .pending_o(timer_pending)
  );

  // Previous operation must finish before the next one is taken
  assign issue_ready_o = (busy_cnt_r == 6'h0);
  assign take = issue_i.valid && issue_ready_o;
  assign is_misc = (issue_i.func == FN_MISC);
  assign is_fix = (issue_i.op == OP_INT);
  assign g_in = (issue_i.op == OP_GF) || (issue_i.op == OP_G);
  assign g_round = (issue_i.op == OP_FG) || (issue_i.op == OP_G);
  assign operand = {issue_i.ra, issue_i.rb};

  // Kernel-only timer writes; user mode is ignored
  assign load_target = take && is_misc && issue_i.kernel
    && (issue_i.misc == MC_SET_TIMER_TARGET);
  assign load_tod = take && is_misc && issue_i.kernel
    && (issue_i.misc == MC_SET_CYCLE_CLOCK);

  // Zero exponent with sign set is a reserved operand
  assign f_rsv = issue_i.ra[31] && (issue_i.ra[30:23] == 8'h00);
  assign g_rsv = issue_i.ra[31] && (issue_i.ra[30:20] == 11'h000);
  assign rsv_hit = !is_misc && !is_fix && (g_in ? g_rsv : f_rsv);
  assign op_zero = g_in ? (issue_i.ra[30:20] == 11'h000) : (issue_i.ra[30:23] == 8'h00);
  assign acc_zero = (acc_frac_r == 64'h0);
  assign zdiv_hit = !is_fix && (((issue_i.func == FN_DIV) && op_zero)
    || ((issue_i.func == FN_RDIV) && acc_zero));

  // Range flags track the accumulator at all times
  assign srange = !acc_zero && ((acc_exp_r > F_EXP_MAX) || (acc_exp_r < -F_EXP_MAX));
  assign drange = !acc_zero && ((acc_exp_r > G_EXP_MAX) || (acc_exp_r < -G_EXP_MAX));
  // A range trap needs a float-format result that cannot hold the value
  assign range_hit = ((issue_i.fmt == RS_SP) && srange)
    || (((issue_i.fmt == RS_DPH) || (issue_i.fmt == RS_DPL)) && drange);
  assign trap = rsv_hit || zdiv_hit || range_hit;

  // Latency of the operation now started
  always_comb begin
    latency = LAT_OTHER;
    case (issue_i.func)
      FN_ADD, FN_SUB, FN_RSUB: latency = is_fix ? LAT_ADD_FIX : LAT_ADD_FLT;
      FN_MUL: latency = is_fix ? LAT_MUL_FIX : (g_round ? LAT_MUL_G : LAT_MUL_F);
      FN_DIV, FN_RDIV: latency = is_fix ? LAT_DIV_FIX : (g_round ? LAT_DIV_G : LAT_DIV_F);
      FN_MISC: begin
        if ((issue_i.misc == MC_FLOAT_SP) || (issue_i.misc == MC_FLOAT_DP)) begin
          latency = LAT_FLOAT;
        end
      end
      default: latency = LAT_OTHER;
    endcase
  end

  // Status word
  always_comb begin
    status_word = STATUS_RESET;
    status_word[ST_NEG] = acc_sign_r;
    status_word[ST_NZ] = !acc_zero;
    status_word[ST_ABORT] = abort_r;
    status_word[ST_DRANGE] = drange;
    status_word[ST_SRANGE] = srange;
    status_word[ST_RESERVED_OPERAND_FLAG] = reserved_operand_flag_r;
    status_word[ST_ZDIV] = zdiv_r;
    status_word[ST_TIMER] = timer_pending;
  end

  // Result selection, taken from the accumulator before the new operation
  always_comb begin
    case (issue_i.fmt)
      RS_SIGN: selected = status_word;
      RS_EXP: selected = {{16{acc_exp_r[15]}}, acc_exp_r};
      RS_INTH: selected = acc_frac_r[63:32];
      RS_INTL: selected = acc_frac_r[31:0];
      RS_DPH: selected = {acc_sign_r, 11'(acc_exp_r + 16'sh0400), acc_frac_r[61:42]};
      RS_DPL: selected = acc_frac_r[41:10];
      RS_SP: selected = {acc_sign_r, 8'(acc_exp_r + 16'sh0080), acc_frac_r[61:39]};
      default: selected = 32'h0;
    endcase
  end

  // Fix: move the binary point to the right of bit 0
  assign fix_shift = 16'sh003F - acc_exp_r;
  assign fix_mag = (acc_exp_r < 0) ? 64'h0
    : ((fix_shift < 0) ? acc_frac_r : (acc_frac_r >> fix_shift[5:0]));
  assign float_val = to_float(operand, issue_i.misc == MC_FLOAT_DP);

  // Fixed-point add family on the full fraction
  always_comb begin
    case (issue_i.func)
      FN_ADD: fix_sum = acc_frac_r + operand;
      FN_SUB: fix_sum = acc_frac_r - operand;
      FN_RSUB: fix_sum = operand - acc_frac_r;
      default: fix_sum = operand;
    endcase
  end

  // Answer to the pipeline, one cycle after the instruction is taken
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_r <= '0;
    end else begin
      result_r.valid <= take;
      result_r.trap <= take && trap;
      if (take) result_r.data <= selected;
    end
  end

  // Busy counter; the pipeline is held off until it drains
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_r <= 6'h0;
    end else if (take && !trap) begin
      busy_cnt_r <= latency - 6'h1;
    end else if (busy_cnt_r != 6'h0) begin
      busy_cnt_r <= busy_cnt_r - 6'h1;
    end
  end

  // Accumulator update; a trapped instruction leaves it untouched
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_sign_r <= 1'b0;
      acc_exp_r <= 16'sh0000;
      acc_frac_r <= 64'h0;
    end else if (take && !trap) begin
      if (is_misc) begin
        case (issue_i.misc)
          MC_FIX: begin
            acc_frac_r <= acc_sign_r ? (~fix_mag + 64'h1) : fix_mag;
            acc_exp_r <= 16'sh003F;
          end
          MC_FLOAT_SP, MC_FLOAT_DP: begin
            {acc_sign_r, acc_exp_r, acc_frac_r} <= float_val;
          end
          MC_SCALE: acc_exp_r <= acc_exp_r + $signed(issue_i.ra[15:0]);
          MC_LOAD_EXPONENT: acc_exp_r <= $signed(issue_i.ra[15:0]);
          MC_WRITE_ACC_SIGN: acc_sign_r <= issue_i.ra[0];
          MC_READ_CYCLE_CLOCK: acc_frac_r <= tod;
          default: acc_frac_r <= acc_frac_r;
        endcase
      end else if (is_fix && (issue_i.func != FN_MUL) && (issue_i.func != FN_DIV)
          && (issue_i.func != FN_RDIV)) begin
        // Double fix load and add family; sign follows the high bit
        acc_frac_r <= fix_sum;
        acc_sign_r <= fix_sum[63];
      end
    end
  end

  // Bus: one wait cycle, then the answer
  assign bus_req = (avs_read || avs_write) && !bus_ack_r;
  assign avs_waitrequest = bus_req;
  assign status_wr = avs_write && bus_ack_r && (avs_address == REG_STATUS);

  // Exception flags; a trap in the same cycle as a bus write wins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      abort_r <= 1'b0;
      reserved_operand_flag_r <= 1'b0;
      zdiv_r <= 1'b0;
    end else begin
      if (take) begin
        abort_r <= trap;
      end else if (status_wr) begin
        abort_r <= 1'b0;
      end
      if (take && rsv_hit) begin
        reserved_operand_flag_r <= 1'b1;
      end else if (status_wr) begin
        reserved_operand_flag_r <= avs_writedata[ST_RESERVED_OPERAND_FLAG];
      end
      if (take && zdiv_hit) begin
        zdiv_r <= 1'b1;
      end else if (status_wr) begin
        zdiv_r <= avs_writedata[ST_ZDIV];
      end
    end
  end

  // Bus answer cycle and read data; unmapped addresses read zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_ack_r <= 1'b0;
      readdata_r <= 32'h0;
    end else begin
      bus_ack_r <= bus_req;
      if (bus_req && avs_read) begin
        case (avs_address)
          REG_STATUS: readdata_r <= status_word;
          REG_TOD_LO: readdata_r <= tod[31:0];
          REG_TOD_HI: readdata_r <= tod[63:32];
          REG_ACC_HI: readdata_r <= acc_frac_r[63:32];
          REG_ACC_LO: readdata_r <= acc_frac_r[31:0];
          REG_ACC_EXP: readdata_r <= {{16{acc_exp_r[15]}}, acc_exp_r};
          default: readdata_r <= 32'h0;
        endcase
      end
    end
  end

  // Bus never writes the sign; it would race the pipeline
  assign avs_readdata = readdata_r;
  assign result_o = result_r;
  // Interrupts are held off in kernel mode
  assign timer_irq_o = timer_pending && !issue_i.kernel;
endmodule // fpumts_core

// File: fpumts_assertions.sv
/*
  Concurrent checks on the accumulator control block's ports.
  Assumes one clock domain and the issue and Avalon handshakes of the core.
*/
`timescale 1ns/100ps
module fpumts_assertions (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire fpumts_pkg::fpumts_issue_t issue_i,
  input wire logic issue_ready_o,
  input wire fpumts_pkg::fpumts_result_t result_o,
  input wire logic timer_irq_o,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  import fpumts_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // An instruction is taken on this edge
  wire take = issue_i.valid && issue_ready_o;
  wire is_fix = issue_i.op == OP_INT;
  // Plain fixed-format result words never range-trap
  wire fix_word = issue_i.fmt == RS_INTH || issue_i.fmt == RS_INTL;
  wire fix_arith = is_fix && issue_i.func != FN_MISC && fix_word;
  wire av_req = avs_read || avs_write;
  sequence s_mulf; take && issue_i.func == FN_MUL && issue_i.op == OP_F; endsequence
  sequence s_divx; take && issue_i.func == FN_DIV && is_fix; endsequence
  sequence s_divg; take && issue_i.func == FN_DIV && issue_i.op == OP_G; endsequence
  sequence s_float; take && issue_i.func == FN_MISC && issue_i.misc == MC_FLOAT_SP; endsequence
  // A trap starts no busy time, so only untrapped takes are timed
  sequence s_ok; !result_o.trap; endsequence
  a_result_after_take: assert property (take |=> result_o.valid)
    else $error("no result after take");
  a_no_spurious: assert property (!take |=> !result_o.valid)
    else $error("result without take");
  a_trap_idle: assert property (result_o.trap |-> result_o.valid && issue_ready_o)
    else $error("trap without result or with busy");
  a_irq_kernel_mask: assert property (issue_i.kernel |-> !timer_irq_o)
    else $error("timer interrupt seen in kernel mode");
  a_mulf_latency: assert property (s_mulf ##1 s_ok |-> (!issue_ready_o)[*7] ##1 issue_ready_o)
    else $error("single multiply latency");
  a_divx_latency: assert property (s_divx ##1 s_ok |-> ##32 !issue_ready_o ##1 issue_ready_o)
    else $error("fixed divide latency");
  a_divg_latency: assert property (s_divg ##1 s_ok |-> ##56 !issue_ready_o ##1 issue_ready_o)
    else $error("double divide latency");
  a_float_latency: assert property (s_float ##1 s_ok |-> (!issue_ready_o)[*2] ##1 issue_ready_o)
    else $error("integer to float latency");
  a_fix_no_trap: assert property (take && fix_arith |=> !result_o.trap && issue_ready_o)
    else $error("fixed operation trapped");
  a_av_one_wait: assert property (av_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access wait too long");
  a_av_idle: assert property (!av_req |-> !avs_waitrequest)
    else $error("wait without request");
endmodule // fpumts_assertions
bind fpumts_core fpumts_assertions u_chk (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue_i),
  .issue_ready_o(issue_ready_o), .result_o(result_o), .timer_irq_o(timer_irq_o),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));

// File: fpumts_pipe_model.sv
/*
  Pipeline side model: issues one coprocessor instruction at a time.
  Assumes issue_ready_o is stable by mid-cycle and results are registered.
*/
`timescale 1ns/100ps
module fpumts_pipe_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire fpumts_pkg::fpumts_result_t result_i,
  output fpumts_pkg::fpumts_issue_t issue_o
);
  import fpumts_pkg::*;
  initial issue_o = '0;
  // Hold the instruction until taken, never overlapping a busy one
  task automatic issue(input fpumts_issue_t q, input int gap, output logic [31:0] d,
                       output logic t);
    int n;
    n = 0;
    repeat (gap) @(posedge clk_i);
    issue_o <= q;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ready_i && n < 100);
    issue_o.valid <= 1'b0;
    #1;
    // Missing answer reads as unknown so the bench flags it
    d = result_i.valid ? result_i.data : 'x;
    t = result_i.valid ? result_i.trap : 1'bx;
    @(posedge clk_i);
  endtask
endmodule // fpumts_pipe_model

// File: tb.sv
/*
  Self-checking bench for the accumulator control block with a small
  integer model. Assumes the pipeline model and checker files are compiled.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  import fpumts_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  fpumts_issue_t issue;
  fpumts_result_t res;
  logic ready, irq, avs_waitrequest;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, r1, r2, xs = 32'h53D0;
  logic [63:0] frac = 64'h0; // Model accumulator fraction
  logic sg = 1'b0; // Model accumulator sign
  int n_errors = 0, checked = 0, cyc = 0, ex = 0, c1, n;
  fpumts_core i_dut (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue),
    .issue_ready_o(ready), .result_o(res), .timer_irq_o(irq), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fpumts_pipe_model u_pipe (.clk_i(clk_i), .ready_i(ready), .result_i(res), .issue_o(issue));
  initial forever #2.5 clk_i = ~clk_i;
  // Cycle count for timing checks
  always @(negedge clk_i) cyc++;
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction
  // Avalon master: hold the request until waitrequest is seen low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic st(input int b, input logic v);
    av(1'b0, REG_STATUS, 32'h0, r1);
    `CHK("status bit", v, r1[b])
  endtask
  // Issue one instruction and compare the returned accumulator portion
  task automatic ins(input logic [2:0] f, o, r, input logic [7:0] m, input logic [31:0] a, b,
                     input logic k, et);
    fpumts_issue_t q;
    logic [31:0] d;
    logic t;
    q = '{1'b1, k, f, o, r, m, a, b};
    u_pipe.issue(q, int'(rnd() % 3), d, t);
    `CHK("trap", et, t)
    if (r == RS_EXP) `CHK("exp", 32'(ex), d)
    if (r == RS_INTH) `CHK("inth", frac[63:32], d)
    if (r == RS_INTL) `CHK("intl", frac[31:0], d)
    if (r == RS_SIGN) `CHK("sign", sg, d[ST_NEG])
    if (!et && o == OP_INT && f == FN_LOAD) {frac, sg} = {a, b, a[31]};
    if (!et && o == OP_INT && f == FN_ADD) frac = frac + {a, b};
    if (!et && f == FN_MISC) begin
      if (m == MC_SCALE) ex = ex + int'(signed'(a));
      if (m == MC_LOAD_EXPONENT) ex = int'(signed'(a));
      if (m == MC_WRITE_ACC_SIGN) sg = a[0];
      if (m == MC_FIX) begin
        frac = frac >> (63 - ex);
        frac = sg ? -frac : frac;
        ex = 63;
      end
    end
  endtask
  task automatic mi(input logic [2:0] r, input logic [7:0] m, input logic [31:0] a, b,
                    input logic k, et);
    ins(FN_MISC, OP_INT, r, m, a, b, k, et);
  endtask
  task automatic summarize();
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    av(1'b0, REG_STATUS, 32'h0, r1);
    `CHK("status reset", STATUS_RESET, r1)
    av(1'b0, 5'h18, 32'h0, r1);
    `CHK("unmapped", 32'h0, r1)
    av(1'b0, REG_TOD_LO, 32'h0, r1);
    c1 = cyc;
    av(1'b0, REG_TOD_LO, 32'h0, r2);
    `CHK("tod step", 32'(cyc - c1), r2 - r1)
    // Clock load raises the timer at once, hidden while in kernel mode
    mi(3'h7, MC_SET_CYCLE_CLOCK, 32'h12, 32'h0, 1'b1, 1'b0);
    `CHK("irq kernel", 1'b0, irq)
    st(ST_TIMER, 1'b1);
    mi(3'h7, MC_SET_CYCLE_CLOCK, 32'h77, 32'h0, 1'b0, 1'b0);
    mi(3'h7, MC_SET_TIMER_TARGET, 32'h0, 32'h0, 1'b0, 1'b0);
    `CHK("irq user", 1'b1, irq)
    av(1'b0, REG_TOD_HI, 32'h0, r1);
    `CHK("tod hi", 32'h12, r1)
    av(1'b0, REG_TOD_LO, 32'h0, r1);
    c1 = cyc;
    mi(3'h7, MC_SET_TIMER_TARGET, 32'h12, r1 + 400, 1'b1, 1'b0);
    mi(3'h7, MC_NOP, 32'h0, 32'h0, 1'b0, 1'b0);
    `CHK("irq cleared", 1'b0, irq)
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("timer fire", 1'b1, (cyc - c1 >= 396) && (cyc - c1 <= 404))
    @(posedge clk_i);
    mi(3'h7, MC_READ_CYCLE_CLOCK, 32'h0, 32'h0, 1'b1, 1'b0);
    frac[63:32] = 32'h12;
    mi(RS_INTH, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b0);
    mi(RS_INTH, MC_NOP, 32'h5, 32'h5, 1'b1, 1'b0);
    // Floating exceptions and the status word
    ins(FN_DIV, OP_F, 3'h7, 8'h00, 32'h0, 32'h0, 1'b1, 1'b1);
    st(ST_ZDIV, 1'b1);
    st(ST_ABORT, 1'b1);
    mi(3'h7, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b0);
    st(ST_ABORT, 1'b0);
    av(1'b1, REG_STATUS, 32'h20, r1);
    av(1'b0, REG_STATUS, 32'h0, r1);
    `CHK("status write", 3'b010, {r1[ST_ZDIV], r1[ST_RESERVED_OPERAND_FLAG], r1[ST_ABORT]})
    av(1'b1, REG_STATUS, 32'h0, r1);
    ins(FN_ADD, OP_F, 3'h7, 8'h00, 32'h8000_0000, 32'h0, 1'b1, 1'b1);
    st(ST_RESERVED_OPERAND_FLAG, 1'b1);
    ins(FN_LOAD, OP_INT, 3'h7, 8'h00, 32'h4000_0000, 32'h0, 1'b1, 1'b0);
    mi(RS_INTH, MC_LOAD_EXPONENT, 32'd200, 32'h0, 1'b1, 1'b0);
    mi(RS_SP, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b1);
    st(ST_SRANGE, 1'b1);
    st(ST_DRANGE, 1'b0);
    mi(RS_DPH, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b0);
    mi(RS_EXP, MC_SCALE, 32'hFFFF_FFFD, 32'h0, 1'b1, 1'b0);
    mi(RS_EXP, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b0);
    // Fixed arithmetic then conversion with a shift and negation
    ins(FN_LOAD, OP_INT, 3'h7, 8'h00, rnd() & 32'h3FFF_FFFF, rnd(), 1'b1, 1'b0);
    ins(FN_ADD, OP_INT, RS_INTL, 8'h00, rnd() & 32'h0FFF_FFFF, rnd(), 1'b1, 1'b0);
    mi(RS_INTH, MC_LOAD_EXPONENT, 32'd62, 32'h0, 1'b1, 1'b0);
    mi(RS_SIGN, MC_WRITE_ACC_SIGN, 32'h1, 32'h0, 1'b1, 1'b0);
    mi(RS_SIGN, MC_FIX, 32'h0, 32'h0, 1'b1, 1'b0);
    mi(RS_INTH, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b0);
    mi(RS_INTL, MC_FLOAT_SP, 32'h1, 32'h0, 1'b1, 1'b0);
    {frac, ex, sg} = {64'h4000_0000_0000_0000, 32'd1, 1'b0};
    mi(RS_EXP, MC_FLOAT_DP, 32'h0, 32'h8000_0000, 1'b1, 1'b0);
    {frac, ex} = {64'h4000_0000_0000_0000, 32'd0};
    ins(FN_MUL, OP_F, RS_INTH, 8'h00, 32'h4080_0000, 32'h0, 1'b1, 1'b0);
    ins(FN_MUL, OP_INT, RS_EXP, 8'h00, 32'h3, 32'h0, 1'b1, 1'b0);
    ins(FN_DIV, OP_INT, 3'h7, 8'h00, 32'h5, 32'h0, 1'b1, 1'b0);
    ins(FN_DIV, OP_G, 3'h7, 8'h00, 32'h4010_0000, 32'h0, 1'b1, 1'b0);
    mi(RS_INTH, MC_NOP, 32'h0, 32'h0, 1'b1, 1'b0);
    summarize();
  end
endmodule // tb
